/* File: include/key_wake_defs.vh */
// constants for the key wakeup stop release block
`ifndef KEY_WAKE_DEFS_VH
`define KEY_WAKE_DEFS_VH
`define KW_ADDR_W 12
`define KW_ENABLE_OFS 12'hf9a
`define KW_SYSCTRL_OFS 12'hf9b
`define KW_STATUS_OFS 12'hf9c
`define KW_PORT_OFS 12'hf9d
`define KW_EN_LSB 4
`define KW_EN_MSB 7
`define KW_ENABLE_RST 4'h0
`define KW_SYS_STOP_BIT 0
`define KW_SYS_RELM_BIT 1
`define KW_SYSCTRL_RST 8'h00
`define KW_ST_STOPPED_BIT 0
`define KW_ST_WARMUP_BIT 1
`define KW_ST_SKIPPED_BIT 2
`define KW_WARMUP_CYCLES 8'h10
`endif

/* File: verilog/key_wake_detect.v */
// release condition detector for stop pin and key wake inputs
`timescale 1ns/1ps
module key_wake_detect (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // pins and control
   input wire stop_pin_i,
   input wire [3:0] key_in_i,
   input wire [3:0] key_en_i,
   input wire relm_i,
   // results
   output wire level_release_o,
   output wire edge_release_o
);
   reg stop_prev_reg;
   wire key_hit;
   // key hit is only honoured in level mode; edge mode leaves keys unused
   assign key_hit = |(key_en_i & ~key_in_i);
   assign level_release_o = stop_pin_i | (relm_i & key_hit);
   assign edge_release_o = relm_i ? level_release_o : (stop_pin_i & ~stop_prev_reg);
   // previous stop pin level for rising edge detection
   always @(posedge clk_i) begin
      if (rst_i) begin
         stop_prev_reg <= 1'b0;
      end else begin
         stop_prev_reg <= stop_pin_i;
      end
   end
endmodule

/* File: verilog/key_wake_stop.v */
// key wakeup stop release controller with wishbone registers
// Functional notes
// - four key enables at bits 7..4 for inputs five..two; one enables.
// - enables write-only, reset zero; low four bits unused.
// - stop left on low level of any enabled key input in level mode only.
// - level mode: stop pin high or enabled key low; edge mode: stop rising edge.
// - release condition present at stop entry skips stop, starts warm-up.
// - stop pin has no enable and always releases.
// - key levels readable through port data register, separate input stage.
`timescale 1ns/1ps
`include "key_wake_defs.vh"
module key_wake_stop (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [11:0] adr_i,
   input wire [7:0] dat_i,
   input wire sel_i,
   output reg [7:0] dat_o,
   output reg ack_o,
   // pins
   input wire stop_pin_i,
   input wire key_wake_in2,
   input wire key_wake_in3,
   input wire key_wake_in4,
   input wire key_wake_in5,
   input wire [3:0] key_port_i,
   // stop status
   output reg stopped_o,
   output reg warmup_o,
   output reg clk_halt_o
);
   // sequencer states
   localparam ST_RUN = 2'd0;
   localparam ST_STOP = 2'd1;
   localparam ST_WARM = 2'd2;

   // registers
   reg [3:0] key_wake_enable_reg;
   reg [7:0] system_ctrl_reg1;
   reg [1:0] state_reg;
   reg [7:0] warm_cnt_reg;
   reg skipped_reg;
   // next values
   reg [1:0] state_next;
   reg [7:0] rd_next;
   // decodes and detector results
   wire [3:0] key_in;
   wire [7:0] status_word;
   wire level_rel;
   wire edge_rel;
   wire wr_stb;
   wire rd_go;
   wire en_wr;
   wire sys_wr;
   wire stop_req;
   wire warm_done;

   // address match, shared by both write decodes
   function reg_sel;
      input [11:0] adr;
      input [11:0] ofs;
      begin
         reg_sel = (adr == ofs);
      end
   endfunction

   // key pins in enable-bit order, lowest numbered key at bit 0
   assign key_in[0] = key_wake_in2;
   assign key_in[1] = key_wake_in3;
   assign key_in[2] = key_wake_in4;
   assign key_in[3] = key_wake_in5;

   // bus strobes; a strobe held through ack is not taken twice
   assign wr_stb = cyc_i & stb_i & we_i & sel_i & ~ack_o;
   assign rd_go = cyc_i & stb_i & ~ack_o;
   assign en_wr = wr_stb & reg_sel(adr_i, `KW_ENABLE_OFS);
   assign sys_wr = wr_stb & reg_sel(adr_i, `KW_SYSCTRL_OFS);

   // status word; bits above the skip flag read zero
   assign status_word[7:3] = 5'h00;
   assign status_word[`KW_ST_SKIPPED_BIT] = skipped_reg;
   assign status_word[`KW_ST_WARMUP_BIT] = warmup_o;
   assign status_word[`KW_ST_STOPPED_BIT] = stopped_o;

   // counter ends at one, not zero, so warm-up lasts exactly the loaded count
   assign stop_req = system_ctrl_reg1[`KW_SYS_STOP_BIT];
   assign warm_done = (warm_cnt_reg == 8'h01);

   key_wake_detect u_detect (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .stop_pin_i(stop_pin_i),
      .key_in_i(key_in),
      .key_en_i(key_wake_enable_reg),
      .relm_i(system_ctrl_reg1[`KW_SYS_RELM_BIT]),
      .level_release_o(level_rel),
      .edge_release_o(edge_rel)
   );

   // key wake enables, write-only
   always @(posedge clk_i) begin
      if (rst_i) begin
         key_wake_enable_reg <= `KW_ENABLE_RST;
      end else if (en_wr) begin
         key_wake_enable_reg <= dat_i[`KW_EN_MSB:`KW_EN_LSB];
      end
   end

   // system control; a write wins over the stop request self-clear in the same cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         system_ctrl_reg1 <= `KW_SYSCTRL_RST;
      end else if (sys_wr) begin
         system_ctrl_reg1 <= dat_i;
      end else if (state_reg == ST_RUN) begin
         system_ctrl_reg1[`KW_SYS_STOP_BIT] <= 1'b0;
      end
   end

   // read mux; enable register is write-only and reads zero
   always @* begin
      rd_next = 8'h00;
      case (adr_i)
         `KW_SYSCTRL_OFS: rd_next = system_ctrl_reg1;
         `KW_STATUS_OFS: rd_next = status_word;
         `KW_PORT_OFS: rd_next = {4'h0, key_port_i};
         default: rd_next = 8'h00;
      endcase
   end

   // single-cycle ack; a strobe still high during ack is refused
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= rd_go;
      end
   end

   // read data stands with ack only, unmapped reads give zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 8'h00;
      end else begin
         dat_o <= rd_go ? rd_next : 8'h00;
      end
   end

   // next state of the stop sequencer
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            // a stop request either stops or goes straight to warm-up
            if (stop_req) begin
               if (level_rel) begin
                  // condition already present: skip stop
                  state_next = ST_WARM;
               end else begin
                  state_next = ST_STOP;
               end
            end
         end
         ST_STOP: begin
            // level or rising edge, as the release mode selects
            if (edge_rel) begin
               state_next = ST_WARM;
            end
         end
         ST_WARM: begin
            // back to run once the counter reaches its end
            if (warm_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // state, warm-up counter and skip flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_RUN;
         warm_cnt_reg <= 8'h00;
         skipped_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg != ST_WARM && state_next == ST_WARM) begin
            warm_cnt_reg <= `KW_WARMUP_CYCLES;
         end else if (state_reg == ST_WARM) begin
            warm_cnt_reg <= warm_done ? 8'h00 : warm_cnt_reg - 8'h01;
         end
         if (state_reg == ST_RUN && stop_req) begin
            skipped_reg <= level_rel;
         end
      end
   end

   // outputs straight from flops, decoded from the next state so they move with it
   always @(posedge clk_i) begin
      if (rst_i) begin
         stopped_o <= 1'b0;
         warmup_o <= 1'b0;
         clk_halt_o <= 1'b0;
      end else begin
         stopped_o <= (state_next == ST_STOP);
         warmup_o <= (state_next == ST_WARM);
         clk_halt_o <= (state_next == ST_STOP); // clock keeps running; halt is only a flag
      end
   end
endmodule

/* File: tb/key_wake_properties.sv */
// assertions on the key wake stop ports
`timescale 1ns/1ps
module key_wake_properties (
   // watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic stop_pin_i,
   input wire logic [7:0] dat_o,
   input wire logic ack_o,
   input wire logic stopped_o,
   input wire logic warmup_o,
   input wire logic clk_halt_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
   a_data_idle: assert property (!ack_o |-> dat_o == 8'h00) else $error("data outside ack");
   a_halt_match: assert property (clk_halt_o == stopped_o) else $error("halt mismatch");
   a_stop_warm: assert property (!(stopped_o && warmup_o)) else $error("stop with warm-up");
   a_skip_entry: assert property ($rose(stopped_o) |-> !$past(stop_pin_i)) else $error("stop despite pin");
   a_pin_release: assert property ($rose(stop_pin_i) && stopped_o |-> ##[1:3] !stopped_o)
      else $error("pin ignored");
   a_warm_len: assert property ($rose(warmup_o) |-> warmup_o[*8] ##1 warmup_o[*8] ##1 !warmup_o)
      else $error("warm-up length");
endmodule

/* File: tb/key_pins_model.sv */
// external key switches and stop line
`timescale 1ns/1ps
module key_pins_model (
   // clock and wanted levels
   input wire logic clk_i,
   input wire logic [4:0] lv_i,
   // pins
   output logic stop_pin_o,
   output logic [3:0] key_o
);
   // keys idle high, stop pin low so it never masks a key release
   initial {key_o, stop_pin_o} = 5'h1e;
   // pins only ever drive toward the block, at full logic levels and never analog
   always @(posedge clk_i) begin
      {key_o, stop_pin_o} <= lv_i;
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the key wake stop block
`timescale 1ns/1ps
module testbench;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sel_i = 0;
   logic [11:0] adr_i = 12'h000;
   logic [7:0] dat_i = 8'h00, rd;
   logic [4:0] lv = 5'h1e;
   wire [7:0] dat_o;
   wire ack_o, stop_pin_i, stopped_o, warmup_o, clk_halt_o;
   wire [3:0] k;
   int n_fail = 0, compares = 0;
   // 40 mhz clock
   always #12.5 clk_i = ~clk_i;
   key_pins_model key_pins_model_inst (.clk_i, .lv_i(lv), .stop_pin_o(stop_pin_i), .key_o(k));
   key_wake_stop key_wake_stop_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o,
      .ack_o, .stop_pin_i, .key_wake_in2(k[0]), .key_wake_in3(k[1]), .key_wake_in4(k[2]),
      .key_wake_in5(k[3]), .key_port_i(k), .stopped_o, .warmup_o, .clk_halt_o);
   task chk(input string nm, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task stop_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // classic cycle held until ack; data taken at that edge
   task wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 1'b1, a, d};
      repeat (20) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      if (ack_o !== 1'b1) begin
         n_fail++;
         stop_test;
      end
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   // bounded wait for the warm-up flag
   task wt(input logic v);
      repeat (40) if (warmup_o !== v) @(posedge clk_i);
      chk("warmup", {7'h0, v}, {7'h0, warmup_o});
      if (warmup_o !== v) stop_test;
   endtask
   task t_regs;
      wb(1, 12'hf9a, 8'hf0);
      wb(0, 12'hf9a, 0);
      chk("enable", 8'h00, rd);
      wb(0, 12'hf9e, 0);
      chk("unmapped", 8'h00, rd);
      lv <= 5'h14;
      wb(0, 12'hf9d, 0);
      chk("port", 8'h0a, rd & 8'h0f);
      lv <= 5'h1f;
   endtask
   task t_skip;
      wb(1, 12'hf9b, 8'h03);
      wb(0, 12'hf9c, 0);
      chk("skip", 8'h06, rd & 8'h07);
      wt(0);
      lv <= 5'h1e;
   endtask
   task t_key;
      wb(1, 12'hf9a, 8'h40);
      wb(1, 12'hf9b, 8'h03);
      repeat (3) @(posedge clk_i);
      chk("halt", 8'h01, {7'h0, clk_halt_o});
      lv <= 5'h1a;
      repeat (4) @(posedge clk_i);
      chk("masked key", 8'h01, {7'h0, stopped_o});
      lv <= 5'h16;
      wt(1);
      wt(0);
      lv <= 5'h1e;
   endtask
   task t_edge;
      wb(1, 12'hf9b, 8'h01);
      repeat (3) @(posedge clk_i);
      chk("edge stop", 8'h01, {7'h0, stopped_o});
      lv <= 5'h1f;
      wt(1);
   endtask
   // mid-run reset clears the enables, so a low key no longer skips stop
   task t_rst;
      wb(1, 12'hf9a, 8'hf0);
      rst_i <= 1;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      chk("reset warmup", 8'h00, {7'h0, warmup_o});
      lv <= 5'h1c;
      repeat (2) @(posedge clk_i);
      wb(1, 12'hf9b, 8'h03);
      repeat (3) @(posedge clk_i);
      chk("reset enables", 8'h01, {7'h0, stopped_o});
      lv <= 5'h1d;
      wt(1);
      wt(0);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      t_regs;
      t_skip;
      t_key;
      t_edge;
      t_rst;
      stop_test;
   end
endmodule
bind key_wake_stop key_wake_properties key_wake_properties_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .stop_pin_i,
   .dat_o, .ack_o, .stopped_o, .warmup_o, .clk_halt_o);
